// file: verilog/reply_frame_pkg.sv
// Constants and carrier types for the fabric reply frame builder
package reply_frame_pkg;

  // Frame header constants
  localparam logic [7:0] ROUTE_REQUEST   = 8'h02;
  localparam logic [7:0] ROUTE_REPLY     = 8'h03;
  localparam logic [7:0] TYPE_SWITCH_SVC = 8'h22;
  localparam logic [7:0] CLASS_F_SERVICE = 8'h0f;

  // Payload command bytes (most significant byte of first word)
  localparam logic [7:0] CMD_REJECT     = 8'h01;
  localparam logic [7:0] CMD_ACCEPT     = 8'h02;
  localparam logic [7:0] CMD_HELLO      = 8'h14;
  localparam logic [7:0] CMD_LINK_STATE = 8'h15;
  localparam logic [7:0] CMD_LINK_ACK   = 8'h16;
  localparam logic [23:0] REJECT_TAIL   = 24'h000000;
  localparam logic [7:0] RESERVED_BYTE  = 8'h00;

  // Reject reason codes
  localparam logic [7:0] RSN_BAD_COMMAND  = 8'h01;
  localparam logic [7:0] RSN_BAD_REVISION = 8'h02;
  localparam logic [7:0] RSN_LOGICAL      = 8'h03;
  localparam logic [7:0] RSN_BAD_SIZE     = 8'h04;
  localparam logic [7:0] RSN_BUSY         = 8'h05;
  localparam logic [7:0] RSN_PROTOCOL     = 8'h07;
  localparam logic [7:0] RSN_UNABLE       = 8'h09;
  localparam logic [7:0] RSN_UNSUPPORTED  = 8'h0b;
  localparam logic [7:0] RSN_ATTACHMENT   = 8'h0c;
  localparam logic [7:0] RSN_VENDOR       = 8'hff;

  // Explanation range limits
  localparam logic [7:0] EXPL_SEC_LO  = 8'h30;
  localparam logic [7:0] EXPL_SEC_HI  = 8'h3f;
  localparam logic [7:0] EXPL_ZONE_LO = 8'h40;
  localparam logic [7:0] EXPL_ZONE_HI = 8'h4f;
  localparam logic [7:0] EXPL_NONE    = 8'h00;

  // Listed explanation codes that pass unchanged into a reject
  localparam int         N_LISTED_EXPL = 15;
  localparam logic [7:0] LISTED_EXPL [N_LISTED_EXPL] = '{
    8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h0e, 8'h0f, 8'h10,
    8'h19, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d
  };

  // Width of the request argument carried in the accept first word
  localparam int         ACCEPT_ARG_W  = 24;

  // Reject cause selector given by the request checker
  typedef enum logic [3:0] {
    CAUSE_BAD_COMMAND, CAUSE_BAD_REVISION, CAUSE_LOGICAL, CAUSE_BAD_SIZE,
    CAUSE_BUSY, CAUSE_PROTOCOL, CAUSE_UNABLE, CAUSE_UNSUPPORTED,
    CAUSE_ATTACHMENT, CAUSE_VENDOR
  } reject_cause_t;

  // Request summary handed in by the request parser
  typedef struct packed {
    logic [23:0] source_identifier;
    logic [23:0] destination_identifier;
    logic [7:0]  command_byte;
    logic        reject;
    logic [3:0]  cause;
    logic [7:0]  explanation;
    logic [7:0]  vendor_detail;
    logic [31:0] accept_word;
  } request_info_t;

  // Reply frame handed to the transmitter
  typedef struct packed {
    logic [7:0]  routing_control_field;
    logic [7:0]  frame_type;
    logic [7:0]  service_class;
    logic [23:0] source_identifier;
    logic [23:0] destination_identifier;
    logic [31:0] first_word;
    logic [31:0] second_word;
    logic        is_reject;
  } reply_frame_t;

endpackage : reply_frame_pkg

// file: verilog/fabric_reply_frame_builder.sv
// Builds accept and reject reply frames for inter-switch service requests
// What this block does
// - Accept reply first word carries 02 in top byte, rest per request
// - Never reply to hello, link state update or link state ack
// - Reply source id is request destination id and vice versa
// - Reject payload: 01000000h, reserved, reason, explanation, vendor byte
// - Unrecognised command code rejects with reason 01
// - Unsupported revision level rejects with reason 02
// - Invalid or inconsistent command and payload rejects with reason 03
// - Payload size mismatch rejects with reason 04
// - Busy device rejects with reason 05
// - Protocol violation rejects with reason 07
// - Unable to perform rejects with reason 09
// - Recognised but unsupported command rejects with reason 0B
// - Invalid attachment state rejects with reason 0C
// - Vendor failure uses reason FF with detail in vendor byte
// - Explanations 00, 01, 03, 04, 05 for parameter and flow errors
// - Explanations 0D, 0E, 0F, 10 for names, timeouts, domain lists
// - Explanations 19, 29, 2A, 2B, 2C, 2D for resource and link states
// - 30h-3Fh security only, 40h-4Fh zoning only; both ranges are passed with any reason, unchecked
// - Reply frames carry routing control 03h, requests 02h
// - Reply frames carry type 22h
// - Requests and replies use class F service
// - Vendor byte meaningful only with vendor reason, else reserved
`timescale 1ns/1ns
`default_nettype none

module fabric_reply_frame_builder (
  // Clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  // Request summary from the parser
  input  wire logic                          req_valid_in,
  input  wire reply_frame_pkg::request_info_t req_info_in,
  output logic                               req_ready_out,
  // Reply frame to the transmitter
  output logic                               reply_valid_out,
  output reply_frame_pkg::reply_frame_t      reply_frame_out,
  input  wire logic                          reply_ready_in,
  // Suppressed request indication
  output logic                               suppressed_out
);

  // Maps a cause selector to its reason code; unknown causes fall to unable
  function automatic logic [7:0] reason_of(input logic [3:0] cause);
    unique case (reply_frame_pkg::reject_cause_t'(cause))
      reply_frame_pkg::CAUSE_BAD_COMMAND:  reason_of = reply_frame_pkg::RSN_BAD_COMMAND;
      reply_frame_pkg::CAUSE_BAD_REVISION: reason_of = reply_frame_pkg::RSN_BAD_REVISION;
      reply_frame_pkg::CAUSE_LOGICAL:      reason_of = reply_frame_pkg::RSN_LOGICAL;
      reply_frame_pkg::CAUSE_BAD_SIZE:     reason_of = reply_frame_pkg::RSN_BAD_SIZE;
      reply_frame_pkg::CAUSE_BUSY:         reason_of = reply_frame_pkg::RSN_BUSY;
      reply_frame_pkg::CAUSE_PROTOCOL:     reason_of = reply_frame_pkg::RSN_PROTOCOL;
      reply_frame_pkg::CAUSE_UNABLE:       reason_of = reply_frame_pkg::RSN_UNABLE;
      reply_frame_pkg::CAUSE_UNSUPPORTED:  reason_of = reply_frame_pkg::RSN_UNSUPPORTED;
      reply_frame_pkg::CAUSE_ATTACHMENT:   reason_of = reply_frame_pkg::RSN_ATTACHMENT;
      reply_frame_pkg::CAUSE_VENDOR:       reason_of = reply_frame_pkg::RSN_VENDOR;
      default:                             reason_of = reply_frame_pkg::RSN_UNABLE;
    endcase
  endfunction : reason_of

  // Security explanations share one block of codes
  function automatic logic in_security_range(input logic [7:0] expl);
    in_security_range = (expl >= reply_frame_pkg::EXPL_SEC_LO) &&
                        (expl <= reply_frame_pkg::EXPL_SEC_HI);
  endfunction : in_security_range

  // Zoning explanations share the next block of codes
  function automatic logic in_zoning_range(input logic [7:0] expl);
    in_zoning_range = (expl >= reply_frame_pkg::EXPL_ZONE_LO) &&
                      (expl <= reply_frame_pkg::EXPL_ZONE_HI);
  endfunction : in_zoning_range

  // Passes listed or ranged explanations; anything reserved becomes 00
  // Ranged codes are not checked further; their meaning is set upstream
  function automatic logic [7:0] explanation_of(input logic [7:0] expl,
                                                 input logic       listed);
    if (listed || in_security_range(expl) || in_zoning_range(expl)) begin
      explanation_of = expl;
    end else begin
      explanation_of = reply_frame_pkg::EXPL_NONE;
    end
  endfunction : explanation_of

  // Vendor byte travels only with the vendor reason, else reads as zero
  function automatic logic [7:0] vendor_byte_of(input logic [7:0] rsn,
                                                 input logic [7:0] detail);
    if (rsn == reply_frame_pkg::RSN_VENDOR) begin
      vendor_byte_of = detail;
    end else begin
      vendor_byte_of = reply_frame_pkg::RESERVED_BYTE;
    end
  endfunction : vendor_byte_of

  // Requests that never get any reply
  function automatic logic no_reply(input logic [7:0] cmd);
    no_reply = (cmd == reply_frame_pkg::CMD_HELLO) ||
               (cmd == reply_frame_pkg::CMD_LINK_STATE) ||
               (cmd == reply_frame_pkg::CMD_LINK_ACK);
  endfunction : no_reply

  logic                          busy_ff;
  logic                          suppressed_ff;
  reply_frame_pkg::reply_frame_t frame_ff;
  reply_frame_pkg::reply_frame_t nxt_frame;
  logic                          take;
  logic [7:0]                    reason;
  logic                          silent;
  logic                          load;
  logic                          drain;
  logic [7:0]                    explanation_byte;
  logic [7:0]                    vendor_byte;
  logic                          expl_listed;
  logic [31:0]                   reject_first;
  logic [31:0]                   reject_second;
  logic [31:0]                   accept_first;
  logic [31:0]                   accept_second;
  logic [reply_frame_pkg::N_LISTED_EXPL-1:0] expl_hit;

  // One reply held at a time; a new request waits until it is drained
  assign req_ready_out   = ~busy_ff;
  assign take            = req_valid_in & ~busy_ff;
  assign reply_valid_out = busy_ff;
  assign reply_frame_out = frame_ff;
  assign suppressed_out  = suppressed_ff;
  assign reason          = reason_of(req_info_in.cause);

  // Hello and link state requests are taken but never answered
  assign silent = no_reply(req_info_in.command_byte);
  assign load   = take & ~silent;
  assign drain  = busy_ff & reply_ready_in;

  // One comparator per listed explanation code
  for (genvar k = 0; k < reply_frame_pkg::N_LISTED_EXPL; k++) begin : g_expl
    assign expl_hit[k] = (req_info_in.explanation ==
                          reply_frame_pkg::LISTED_EXPL[k]);
  end
  assign expl_listed = |expl_hit;

  // Reject detail bytes; reserved codes never reach the wire
  assign explanation_byte = explanation_of(req_info_in.explanation,
                                           expl_listed);
  assign vendor_byte      = vendor_byte_of(reason,
                                           req_info_in.vendor_detail);

  // Reject payload: fixed head word, then reserved, reason, detail bytes
  assign reject_first  = {reply_frame_pkg::CMD_REJECT,
                          reply_frame_pkg::REJECT_TAIL};
  assign reject_second = {reply_frame_pkg::RESERVED_BYTE, reason,
                          explanation_byte, vendor_byte};

  // Accept payload; words past the first belong to the request kind
  assign accept_first  = {
    reply_frame_pkg::CMD_ACCEPT,
    req_info_in.accept_word[reply_frame_pkg::ACCEPT_ARG_W-1:0]
  };
  assign accept_second = req_info_in.accept_word;

  // Reply frame assembly; header fields are fixed for every reply
  always_comb begin
    nxt_frame = frame_ff;
    nxt_frame.routing_control_field  = reply_frame_pkg::ROUTE_REPLY;
    nxt_frame.frame_type             = reply_frame_pkg::TYPE_SWITCH_SVC;
    nxt_frame.service_class          = reply_frame_pkg::CLASS_F_SERVICE;
    nxt_frame.source_identifier      = req_info_in.destination_identifier;
    nxt_frame.destination_identifier = req_info_in.source_identifier;
    nxt_frame.is_reject              = req_info_in.reject;
    if (req_info_in.reject) begin
      nxt_frame.first_word  = reject_first;
      nxt_frame.second_word = reject_second;
    end else begin
      nxt_frame.first_word  = accept_first;
      nxt_frame.second_word = accept_second;
    end
  end

  // Reply holding flag; suppressed requests never load it
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      busy_ff <= 1'b0;
    end else if (load) begin
      busy_ff <= 1'b1;
    end else if (drain) begin
      busy_ff <= 1'b0;
    end
  end

  // One-cycle pulse when a request is dropped without reply
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      suppressed_ff <= 1'b0;
    end else begin
      suppressed_ff <= take & silent;
    end
  end

  // Frame register, loaded only when a reply is accepted for building
  // Held frame stays put while the peer stalls, so no copy is needed
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      frame_ff <= '0;
    end else if (load) begin
      frame_ff <= nxt_frame;
    end
  end

endmodule : fabric_reply_frame_builder

`default_nettype wire

// file: sim/reply_frame_properties.sv
// Port assertions for the fabric reply frame builder
`timescale 1ns/1ns
`default_nettype none
module reply_frame_properties (
  // Clock, reset and handshakes
  input wire logic clock_in, rst_n_in, req_valid_in, req_ready_out,
  input wire logic reply_valid_out, reply_ready_in, suppressed_out,
  // Request and reply contents
  input wire reply_frame_pkg::request_info_t req_info_in,
  input wire reply_frame_pkg::reply_frame_t  reply_frame_out
);
  // Reason per cause selector; unknown selectors fall back to unable
  localparam logic [7:0] RSN [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h07, 8'h09, 8'h0b, 8'h0c, 8'hff, 8'h09, 8'h09, 8'h09, 8'h09, 8'h09,
    8'h09};
  reply_frame_pkg::request_info_t q;
  reply_frame_pkg::reply_frame_t  f;
  logic take, mute;
  // Taken request, and whether it is a kind that never gets a reply
  assign q = req_info_in;
  assign f = reply_frame_out;
  assign take = req_valid_in && req_ready_out;
  assign mute = q.command_byte inside {8'h14, 8'h15, 8'h16};
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_silent_none: assert property (take && mute
    |=> suppressed_out && !reply_valid_out) else $error("silent reply");
  a_ids_swapped: assert property (take && !mute
    |=> f.source_identifier == $past(q.destination_identifier)
    && f.destination_identifier == $past(q.source_identifier))
    else $error("ids not swapped");
  a_accept_word: assert property (take && !mute && !q.reject
    |=> f.first_word == {8'h02, $past(q.accept_word[23:0])})
    else $error("bad accept word");
  a_reason_code: assert property (take && !mute && q.reject
    |=> f.second_word[23:16] == RSN[$past(q.cause)]) else $error("reason");
  a_reject_head: assert property (reply_valid_out && f.is_reject
    |-> f.first_word == 32'h01000000 && f.second_word[31:24] == 8'h00)
    else $error("bad reject head");
  a_vendor_quiet: assert property (reply_valid_out && f.is_reject
    && f.second_word[23:16] != 8'hff |-> f.second_word[7:0] == 8'h00)
    else $error("vendor byte set");
  a_header_fixed: assert property (reply_valid_out
    |-> {f.routing_control_field, f.frame_type, f.service_class}
    == {8'h03, 8'h22, 8'h0f}) else $error("bad header");
  a_reply_holds: assert property (reply_valid_out && !reply_ready_in
    |=> reply_valid_out && $stable(f)) else $error("reply dropped");
  // Main scenarios reached
  c_reject: cover property (take && q.reject && !mute);
  c_silent: cover property (suppressed_out);
  c_stall: cover property (reply_valid_out && !reply_ready_in);
endmodule : reply_frame_properties
bind fabric_reply_frame_builder reply_frame_properties
  reply_frame_properties_inst (.clock_in, .rst_n_in, .req_valid_in,
  .req_ready_out, .reply_valid_out, .reply_ready_in, .suppressed_out,
  .req_info_in, .reply_frame_out);
`default_nettype wire

// file: sim/reply_sink.sv
// Peer fabric controller model taking reply frames
`timescale 1ns/1ns
`default_nettype none
module reply_sink (
  // Clock, reset and pacing
  input  wire logic clock_in, rst_n_in, slow_in,
  // Reply handshake
  input  wire logic                          valid_in,
  input  wire reply_frame_pkg::reply_frame_t frame_in,
  output logic                               ready_out,
  // Last frame taken and how many
  output reply_frame_pkg::reply_frame_t      frame_out,
  output logic [7:0]                         count_out
);
  // Slow mode drops ready every other cycle to stall the builder
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) ready_out <= 1'b1;
    else ready_out <= slow_in ? !ready_out : 1'b1;
  end
  // Non class F frames are dropped; vendor byte is not interpreted
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) count_out <= 8'h00;
    else if (valid_in && ready_out && frame_in.service_class == 8'h0f) begin
      count_out <= count_out + 8'h01;
      frame_out <= frame_in;
    end
  end
endmodule : reply_sink
`default_nettype wire

// file: sim/tb_fabric_reply_frame_builder.sv
// Testbench for the fabric reply frame builder
`timescale 1ns/1ns
`default_nettype none
module tb_fabric_reply_frame_builder;
  logic clock_in, rst_n_in, req_valid_in, req_ready_out, slow;
  logic reply_valid_out, reply_ready_in, suppressed_out;
  reply_frame_pkg::request_info_t ri, req_info_in;
  reply_frame_pkg::reply_frame_t  reply_frame_out, got;
  logic [7:0] rx_count, seen;
  int n_errors = 0, checks_done = 0, cycles = 0;
  logic [7:0] rsn [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09,
    8'h0b, 8'h0c, 8'hff};
  logic [7:0] ex [18] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h0e,
    8'h0f, 8'h10, 8'h19, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h35, 8'h02,
    8'h4f};
  fabric_reply_frame_builder fabric_reply_frame_builder_inst (.clock_in,
    .rst_n_in, .req_valid_in, .req_info_in, .req_ready_out,
    .reply_valid_out, .reply_frame_out, .reply_ready_in, .suppressed_out);
  reply_sink reply_sink_inst (.clock_in, .rst_n_in, .slow_in(slow),
    .valid_in(reply_valid_out), .frame_in(reply_frame_out),
    .ready_out(reply_ready_in), .frame_out(got), .count_out(rx_count));
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Offer one request and hold it until the builder takes it
  task automatic send(input reply_frame_pkg::request_info_t r);
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_info_in <= r;
    slow <= r.source_identifier[0];
    @(negedge clock_in);
    while (req_ready_out !== 1'b1) @(negedge clock_in);
    @(posedge clock_in);
    req_valid_in <= 1'b0;
  endtask : send
  // Reply held after the taking edge, then judged once the peer has it
  task automatic expect_frame(input logic [31:0] w1, w2,
                              input logic [23:0] s, d);
    logic [31:0] hdr;
    @(negedge clock_in);
    chk({31'h0, req_ready_out}, 32'h0);
    while (rx_count === seen) @(negedge clock_in);
    seen = rx_count;
    hdr = {8'h00, got.routing_control_field, got.frame_type,
           got.service_class};
    chk(got.first_word, w1);
    chk(got.second_word, w2);
    chk({8'h00, got.source_identifier}, {8'h00, s});
    chk({8'h00, got.destination_identifier}, {8'h00, d});
    chk(hdr, 32'h0003220f);
    chk({31'h0, got.is_reject}, {31'h0, w1 == 32'h01000000});
  endtask : expect_frame
  // Every reason, listed and reserved explanations, an unknown cause
  task automatic t_reject();
    for (int i = 0; i < 18; i++) begin
      ri = '0;
      ri.source_identifier = 24'h010200 + 24'(i);
      ri.destination_identifier = 24'h0a0b0c;
      ri.reject = 1'b1;
      ri.cause = (i == 17) ? 4'hf : 4'(i % 10);
      ri.explanation = ex[i];
      ri.vendor_detail = 8'h5a;
      send(ri);
      expect_frame(32'h01000000, {8'h00, (i == 17) ? 8'h09 : rsn[i % 10],
        (i == 16) ? 8'h00 : ex[i], (i % 10 == 9) ? 8'h5a : 8'h00},
        24'h0a0b0c, 24'h010200 + 24'(i));
    end
  endtask : t_reject
  task automatic t_accept();
    ri = '0;
    ri.source_identifier = 24'hfffffd;
    ri.destination_identifier = 24'h123456;
    ri.command_byte = 8'h11;
    ri.accept_word = 32'h77abcdef;
    send(ri);
    expect_frame(32'h02abcdef, 32'h77abcdef, 24'h123456, 24'hfffffd);
  endtask : t_accept
  // Hello and link state kinds, even when flagged as rejects
  task automatic t_silent();
    for (int i = 0; i < 3; i++) begin
      ri = '0;
      ri.command_byte = 8'h14 + 8'(i);
      ri.reject = i[0];
      send(ri);
      @(negedge clock_in);
      chk({31'h0, suppressed_out}, 32'h1);
      chk({31'h0, req_ready_out}, 32'h1);
      repeat (4) @(negedge clock_in);
      chk({24'h0, rx_count}, {24'h0, seen});
    end
  endtask : t_silent
  task automatic final_report();
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // Hang guard, far above the under a hundred cycles the tests need
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_info_in = '0;
    slow = 1'b0;
    seen = 8'h00;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reject();
    t_accept();
    t_silent();
    final_report();
  end
endmodule : tb_fabric_reply_frame_builder
`default_nettype wire
